// file: logic/asrb_local_bank.sv
// per-channel copies of the local register
// assumes write strobe and mask come from the serial engine on ref_clk
`timescale 1ns/10ps
module asrb_local_bank (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic wr_en,
  input wire logic [5:0] wr_mask,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] rd_sel,
  output logic [7:0] rd_data,
  output logic [47:0] all_values
);
  logic [7:0] copy_r [0:asrb_pkg::NUM_LOCAL-1];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < asrb_pkg::NUM_LOCAL; k++) begin
        copy_r[k] <= asrb_pkg::RST_LOCAL;
      end
    end else begin
      for (int k = 0; k < asrb_pkg::NUM_LOCAL; k++) begin
        if (soft_rst) begin
          copy_r[k] <= asrb_pkg::RST_LOCAL;
        end else if (wr_en && wr_mask[k]) begin
          copy_r[k] <= wr_data;
        end
      end
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (int'(rd_sel) < asrb_pkg::NUM_LOCAL) begin
      rd_data = copy_r[rd_sel];
    end
    for (int k = 0; k < asrb_pkg::NUM_LOCAL; k++) begin
      all_values[k*8 +: 8] = copy_r[k];
    end
  end
endmodule

// file: logic/asrb_pkg.sv
// constants, field positions and types for the serial register bank
// assumes one core clock; serial pins are sampled by the bank itself
package asrb_pkg;

  // register addresses carried in the 13-bit address of an instruction
  localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] ADDR_CHIP_IDENTIFIER = 13'h0001;
  localparam logic [12:0] ADDR_SPEED_GRADE = 13'h0002;
  localparam logic [12:0] ADDR_CH_INDEX = 13'h0005;
  localparam logic [12:0] ADDR_POWER = 13'h0008;
  localparam logic [12:0] ADDR_DUTY = 13'h0009;
  localparam logic [12:0] ADDR_CLK_DIV = 13'h000B;
  localparam logic [12:0] ADDR_LOCAL_OFS = 13'h0010;
  localparam logic [12:0] ADDR_XFER = 13'h00FF;

  // values after reset
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [5:0] RST_CH_INDEX = 6'h3F;
  localparam logic [1:0] RST_POWER_MODE = 2'h0;
  localparam logic RST_PIN_FUNC = 1'b0;
  localparam logic RST_DCS = 1'b1;
  localparam logic [2:0] RST_CLK_DIV = 3'h0;
  localparam logic [7:0] RST_LOCAL = 8'h00;

  // port configuration fields, mirrored nibbles
  localparam int PC_LSB_HI = 6;
  localparam int PC_LSB_LO = 1;
  localparam int PC_SOFT_HI = 5;
  localparam int PC_SOFT_LO = 2;
  localparam logic [7:0] PC_LSB_MASK = 8'h42;

  // power register fields
  localparam int PW_PIN_FUNC = 5;
  localparam logic [1:0] PM_RUN = 2'h0;
  localparam logic [1:0] PM_FULL_PD = 2'h1;
  localparam logic [1:0] PM_STANDBY = 2'h2;
  localparam logic [1:0] PM_DIG_RESET = 2'h3;

  // channel copies: four data pairs, then frame clock, then data clock
  localparam int NUM_LOCAL = 6;
  localparam int IDX_FRAME_CLK = 4;
  localparam int IDX_DATA_CLK = 5;

  // instruction word layout and counts
  localparam int INSTR_RW = 15;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [1:0] WLEN_STREAM = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_INSTR, ST_DATA, ST_DONE} asrb_state_t;

endpackage

// file: logic/asrb_sync.sv
// two-stage synchroniser for pin inputs
// assumes inputs are asynchronous to ref_clk
`timescale 1ns/10ps
module asrb_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// file: logic/asrb_top.sv
// serial-port register bank of a four-channel converter
// assumes sclk well below ref_clk/8 and cs setup of a few ref_clk cycles
`timescale 1ns/10ps
module asrb_top #(
  parameter logic [7:0] CHIP_IDENTIFIER = 8'h5A,   // arbitrary value
  parameter logic [2:0] SPEED_GRADE = 3'h2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  input wire logic pdwn_pin,
  output logic lsb_first,
  output logic [5:0] chan_index,
  output logic full_powerdown,
  output logic standby,
  output logic digital_reset,
  output logic dcs_enable,
  output logic [2:0] clk_div_ratio,
  output logic div_tick,
  output logic override_start,
  output logic [47:0] local_values
);
  logic [3:0] pin_s;
  logic sclk_d_r;
  asrb_pkg::asrb_state_t st_r;
  logic [15:0] instr_r;
  logic [7:0] dat_r;
  logic [3:0] bcnt_r;
  logic [1:0] bytes_left_r;
  logic [12:0] addr_r;
  logic rd_r;
  logic [7:0] out_r;
  logic soft_req_r;
  logic [1:0] power_mode_r;
  logic pin_func_r;
  logic [2:0] div_cnt_r;
  logic [7:0] rd_val;
  logic [7:0] local_rd;

  function automatic logic [7:0] shift_in8(input logic [7:0] v, input logic b,
                                           input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  function automatic logic [15:0] shift_in16(input logic [15:0] v, input logic b,
                                             input logic lsb);
    return lsb ? {b, v[15:1]} : {v[14:0], b};
  endfunction

  function automatic logic [12:0] addr_step(input logic [12:0] a, input logic lsb);
    return lsb ? 13'(a + 13'h0001) : 13'(a - 13'h0001);
  endfunction

  // lowest set select wins, so all-set reads the first data channel
  function automatic logic [2:0] pick_channel(input logic [5:0] idx);
    logic [2:0] sel;
    sel = 3'h0;
    for (int k = asrb_pkg::NUM_LOCAL - 1; k >= 0; k--) begin
      if (idx[k]) begin
        sel = 3'(k);
      end
    end
    return sel;
  endfunction

  asrb_sync #(.WIDTH(4)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in({pdwn_pin, sdio_i, spi_cs_n, spi_sclk}),
    .sync_out(pin_s)
  );

  wire sclk_s = pin_s[0];
  wire cs_n_s = pin_s[1];
  wire sdi_s = pin_s[2];
  wire pdwn_s = pin_s[3];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire in_instr = (st_r == asrb_pkg::ST_IDLE) || (st_r == asrb_pkg::ST_INSTR);
  wire instr_done = !cs_n_s && in_instr && sclk_rise && (bcnt_r == asrb_pkg::INSTR_LAST);
  wire [15:0] instr_nxt = shift_in16(instr_r, sdi_s, lsb_first);
  wire byte_done = !cs_n_s && (st_r == asrb_pkg::ST_DATA) && sclk_rise &&
                   (bcnt_r[2:0] == asrb_pkg::BYTE_LAST);
  wire [7:0] dat_nxt = shift_in8(dat_r, sdi_s, lsb_first);
  wire wr_fire = byte_done && !rd_r;
  wire [12:0] rd_addr = instr_done ? instr_nxt[12:0] : addr_step(addr_r, lsb_first);
  wire wr_port = wr_fire && (addr_r == asrb_pkg::ADDR_PORT_CFG);
  wire wr_local = wr_fire && (addr_r == asrb_pkg::ADDR_LOCAL_OFS);

  // serial sequencer: instruction, then data bytes counted by word length
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= asrb_pkg::ST_IDLE;
      instr_r <= 16'h0000;
      dat_r <= 8'h00;
      bcnt_r <= 4'h0;
      bytes_left_r <= 2'h0;
      addr_r <= 13'h0000;
      rd_r <= 1'b0;
    end else if (cs_n_s) begin
      st_r <= asrb_pkg::ST_IDLE;
      bcnt_r <= 4'h0;
      rd_r <= 1'b0;
    end else begin
      case (st_r)
        asrb_pkg::ST_IDLE, asrb_pkg::ST_INSTR: begin
          st_r <= asrb_pkg::ST_INSTR;
          if (sclk_rise) begin
            instr_r <= instr_nxt;
            bcnt_r <= 4'(bcnt_r + 4'h1);
          end
          if (instr_done) begin
            st_r <= asrb_pkg::ST_DATA;
            rd_r <= instr_nxt[asrb_pkg::INSTR_RW];
            bytes_left_r <= instr_nxt[14:13];
            addr_r <= instr_nxt[12:0];
            bcnt_r <= 4'h0;
          end
        end
        asrb_pkg::ST_DATA: begin
          if (sclk_rise) begin
            dat_r <= dat_nxt;
            bcnt_r <= 4'(bcnt_r + 4'h1);
          end
          if (byte_done) begin
            bcnt_r <= 4'h0;
            addr_r <= addr_step(addr_r, lsb_first);
            if (bytes_left_r == 2'h0) begin
              st_r <= asrb_pkg::ST_DONE;
            end else if (bytes_left_r != asrb_pkg::WLEN_STREAM) begin
              bytes_left_r <= 2'(bytes_left_r - 2'h1);
            end
          end
        end
        asrb_pkg::ST_DONE: begin
          st_r <= asrb_pkg::ST_DONE;
        end
        default: begin
          st_r <= asrb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // readback: line turns to output on the fall after the address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out_r <= 8'h00;
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
    end else if (cs_n_s) begin
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
    end else begin
      if ((instr_done && instr_nxt[asrb_pkg::INSTR_RW]) || (byte_done && rd_r)) begin
        out_r <= rd_val;
      end else if (sclk_fall && (st_r == asrb_pkg::ST_DATA) && rd_r) begin
        sdio_oe <= 1'b1;
        sdio_o <= lsb_first ? out_r[0] : out_r[7];
        out_r <= lsb_first ? {1'b0, out_r[7:1]} : {out_r[6:0], 1'b0};
      end else if (sclk_fall && (st_r == asrb_pkg::ST_DONE)) begin
        sdio_oe <= 1'b0;
      end
    end
  end

  // read multiplexer; open bits and unlisted addresses read zero
  always_comb begin
    case (rd_addr)
      asrb_pkg::ADDR_PORT_CFG:
        rd_val = asrb_pkg::RST_PORT_CFG | (lsb_first ? asrb_pkg::PC_LSB_MASK : 8'h00);
      asrb_pkg::ADDR_CHIP_IDENTIFIER: rd_val = CHIP_IDENTIFIER;
      asrb_pkg::ADDR_SPEED_GRADE: rd_val = {1'b0, SPEED_GRADE, 4'h0};
      asrb_pkg::ADDR_CH_INDEX: rd_val = {2'b00, chan_index};
      asrb_pkg::ADDR_POWER: rd_val = {2'b00, pin_func_r, 3'b000, power_mode_r};
      asrb_pkg::ADDR_DUTY: rd_val = {7'h00, dcs_enable};
      asrb_pkg::ADDR_CLK_DIV: rd_val = {5'h00, clk_div_ratio};
      asrb_pkg::ADDR_LOCAL_OFS: rd_val = local_rd;
      default: rd_val = 8'h00;
    endcase
  end

  // port configuration; soft bits never hold, so they read back zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lsb_first <= 1'b0;
      soft_req_r <= 1'b0;
    end else begin
      soft_req_r <= wr_port && (dat_nxt[asrb_pkg::PC_SOFT_HI] ||
                                dat_nxt[asrb_pkg::PC_SOFT_LO]);
      if (soft_req_r) begin
        lsb_first <= 1'b0;
      end else if (wr_port) begin
        lsb_first <= dat_nxt[asrb_pkg::PC_LSB_HI] | dat_nxt[asrb_pkg::PC_LSB_LO];
      end
    end
  end

  // global registers: single copy, channel index plays no part
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chan_index <= asrb_pkg::RST_CH_INDEX;
      power_mode_r <= asrb_pkg::RST_POWER_MODE;
      pin_func_r <= asrb_pkg::RST_PIN_FUNC;
      dcs_enable <= asrb_pkg::RST_DCS;
      clk_div_ratio <= asrb_pkg::RST_CLK_DIV;
    end else if (soft_req_r) begin
      chan_index <= asrb_pkg::RST_CH_INDEX;
      power_mode_r <= asrb_pkg::RST_POWER_MODE;
      pin_func_r <= asrb_pkg::RST_PIN_FUNC;
      dcs_enable <= asrb_pkg::RST_DCS;
      clk_div_ratio <= asrb_pkg::RST_CLK_DIV;
    end else if (wr_fire) begin
      case (addr_r)
        asrb_pkg::ADDR_CH_INDEX: chan_index <= dat_nxt[5:0];
        asrb_pkg::ADDR_POWER: begin
          power_mode_r <= dat_nxt[1:0];
          pin_func_r <= dat_nxt[asrb_pkg::PW_PIN_FUNC];
        end
        asrb_pkg::ADDR_DUTY: dcs_enable <= dat_nxt[0];
        asrb_pkg::ADDR_CLK_DIV: clk_div_ratio <= dat_nxt[2:0];
        default: chan_index <= chan_index;
      endcase
    end
  end

  // transfer bit is a one-cycle strobe, so the register reads zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      override_start <= 1'b0;
    end else begin
      override_start <= wr_fire && (addr_r == asrb_pkg::ADDR_XFER) && dat_nxt[0];
    end
  end

  // pin forces full power-down, or standby when the pin function bit is set, over the register field while it is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_powerdown <= 1'b0;
      standby <= 1'b0;
      digital_reset <= 1'b0;
    end else begin
      full_powerdown <= pdwn_s ? !pin_func_r : (power_mode_r == asrb_pkg::PM_FULL_PD);
      standby <= pdwn_s ? pin_func_r : (power_mode_r == asrb_pkg::PM_STANDBY);
      digital_reset <= !pdwn_s && (power_mode_r == asrb_pkg::PM_DIG_RESET);
    end
  end

  // divided clock strobe: one tick every ratio+1 cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= 3'h0;
      div_tick <= 1'b0;
    end else if (div_cnt_r >= clk_div_ratio) begin
      div_cnt_r <= 3'h0;
      div_tick <= 1'b1;
    end else begin
      div_cnt_r <= 3'(div_cnt_r + 3'h1);
      div_tick <= 1'b0;
    end
  end

  asrb_local_bank u_bank (
    .ref_clk(ref_clk),
    .rst(rst),
    .soft_rst(soft_req_r),
    .wr_en(wr_local),
    .wr_mask(chan_index),
    .wr_data(dat_nxt),
    .rd_sel(pick_channel(chan_index)),
    .rd_data(local_rd),
    .all_values(local_values)
  );

  a_port_fixed_bits: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_addr == asrb_pkg::ADDR_PORT_CFG) |->
      (rd_val[4:3] == 2'b11) && !rd_val[7] && !rd_val[0] && !rd_val[5] && !rd_val[2])
    else $error("port config fixed bits wrong");
  a_soft_reset_defaults: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_port && dat_nxt[5]) |-> ##2 (chan_index == 6'h3F) && dcs_enable &&
      (power_mode_r == 2'h0) && (clk_div_ratio == 3'h0) && (local_values == 48'h0))
    else $error("soft reset left a register changed");
  a_soft_self_clear: assert property (@(posedge ref_clk) disable iff (rst)
    soft_req_r |=> !soft_req_r)
    else $error("soft reset request held");
  a_mirror_order: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_port && !dat_nxt[5] && !dat_nxt[2] && (dat_nxt[6] ^ dat_nxt[1])) |=> lsb_first)
    else $error("mirrored bit order not honoured");
  a_all_copies_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_local && (chan_index == 6'h3F)) |=>
      (local_values == {6{$past(dat_nxt)}}))
    else $error("broadcast write missed a copy");
  a_unselected_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_local && !chan_index[0] && !soft_req_r) |=> $stable(local_values[7:0]))
    else $error("unselected copy changed");
  a_read_first_chan: assert property (@(posedge ref_clk) disable iff (rst)
    (rd_addr == asrb_pkg::ADDR_LOCAL_OFS && chan_index[0]) |->
      (rd_val == local_values[7:0]))
    else $error("local read not from first data channel");
  a_global_write: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_fire && addr_r == asrb_pkg::ADDR_POWER && chan_index == 6'h00) |=>
      (power_mode_r == $past(dat_nxt[1:0])))
    else $error("global write blocked by index");
  a_pin_standby: assert property (@(posedge ref_clk) disable iff (rst)
    (pdwn_s && pin_func_r) |=> standby && !full_powerdown)
    else $error("pin did not give standby");
  a_override_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    override_start |=> !override_start)
    else $error("override strobe longer than one cycle");
  a_drive_only_read: assert property (@(posedge ref_clk) disable iff (rst)
    sdio_oe |-> rd_r)
    else $error("data line driven outside a read");

  c_read_frame: cover property (@(posedge ref_clk) disable iff (rst) byte_done && rd_r);
  c_broadcast_write: cover property (@(posedge ref_clk) disable iff (rst)
    wr_local && (chan_index == 6'h3F));
  c_soft_reset: cover property (@(posedge ref_clk) disable iff (rst) soft_req_r);
  c_pin_standby: cover property (@(posedge ref_clk) disable iff (rst) standby && pdwn_s);
endmodule

// file: sim/adc_spi_register_bank_tb.sv
// self-checking bench for the serial register bank
// assumes the controller model in asrb_spi_master
`timescale 1ns/10ps
module adc_spi_register_bank_tb;
  localparam logic [7:0] CHIP_CODE = 8'hA7; // arbitrary value
  localparam logic [12:0] A_PC = asrb_pkg::ADDR_PORT_CFG;
  localparam logic [12:0] A_ID = asrb_pkg::ADDR_CHIP_IDENTIFIER;
  localparam logic [12:0] A_IX = asrb_pkg::ADDR_CH_INDEX;
  localparam logic [12:0] A_PW = asrb_pkg::ADDR_POWER;
  localparam logic [12:0] A_DC = asrb_pkg::ADDR_DUTY;
  localparam logic [12:0] A_DV = asrb_pkg::ADDR_CLK_DIV;
  localparam logic [12:0] A_LC = asrb_pkg::ADDR_LOCAL_OFS;
  localparam logic [12:0] A_XF = asrb_pkg::ADDR_XFER;
  logic ref_clk, rst, spi_sclk, spi_cs_n, sdio_pin, sdio_o, sdio_oe, m_out, m_oe;
  logic pdwn_pin, lsb_first, full_powerdown, standby, digital_reset, dcs_enable;
  logic div_tick, override_start, junk_r, lsb_mode;
  logic [5:0] chan_index;
  logic [2:0] clk_div_ratio;
  logic [47:0] local_values;
  int mismatches = 0;
  int checks_done = 0;
  int pulses = 0;

  // a released line shows a changing pattern, not its last value
  assign sdio_pin = sdio_oe ? sdio_o : (m_oe ? m_out : junk_r);

  asrb_top #(.CHIP_IDENTIFIER(CHIP_CODE), .SPEED_GRADE(3'h2)) i_dut (
    .ref_clk(ref_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .sdio_i(sdio_pin), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .pdwn_pin(pdwn_pin),
    .lsb_first(lsb_first), .chan_index(chan_index), .full_powerdown(full_powerdown),
    .standby(standby), .digital_reset(digital_reset), .dcs_enable(dcs_enable),
    .clk_div_ratio(clk_div_ratio), .div_tick(div_tick), .override_start(override_start),
    .local_values(local_values));

  asrb_spi_master i_master (.ref_clk(ref_clk), .sdio_pin(sdio_pin), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .m_out(m_out), .m_oe(m_oe));

  always @(posedge ref_clk) begin
    junk_r <= ~junk_r;
    if (override_start === 1'b1)
      pulses++;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_sig(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t pins %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] x;
    i_master.frame(1'b0, 2'h0, a, {d, 8'h00}, lsb_mode, x);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] x;
    i_master.frame(1'b1, 2'h0, a, 16'h0000, lsb_mode, x);
    chk_byte(x, exp);
  endtask

  task automatic tick_gap(output int n);
    int w;
    w = 0;
    while (div_tick !== 1'b1 && w < 20) begin
      @(negedge ref_clk);
      w++;
    end
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (div_tick !== 1'b1 && n < 20);
  endtask

  task automatic t_defaults;
    rd_chk(A_PC, 8'h18);
    rd_chk(A_ID, CHIP_CODE);
    rd_chk(asrb_pkg::ADDR_SPEED_GRADE, 8'h20);
    rd_chk(A_IX, 8'h3F);
    rd_chk(A_PW, 8'h00);
    rd_chk(A_DC, 8'h01);
    rd_chk(A_DV, 8'h00);
    rd_chk(A_XF, 8'h00);
    rd_chk(13'h0013, 8'h00);
    wr(A_ID, 8'h00);
    rd_chk(A_ID, CHIP_CODE);
    chk_sig(48'({dcs_enable, chan_index}), 48'h7F);
  endtask

  task automatic t_power;
    logic [2:0] exp [4] = '{3'b000, 3'b100, 3'b010, 3'b001};
    wr(A_IX, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(A_PW, 8'(m));
      chk_sig(48'({full_powerdown, standby, digital_reset}), 48'(exp[m]));
    end
    wr(A_PW, 8'h00);
    pdwn_pin = 1'b1;
    wr(A_PW, 8'h00);
    chk_sig(48'({full_powerdown, standby}), 48'h2);
    wr(A_PW, 8'h20);
    chk_sig(48'({full_powerdown, standby}), 48'h1);
    pdwn_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk_sig(48'({full_powerdown, standby}), 48'h0);
  endtask

  task automatic t_clock;
    int n;
    wr(A_DC, 8'hFF);
    rd_chk(A_DC, 8'h01);
    wr(A_DC, 8'h00);
    chk_sig(48'(dcs_enable), 48'h0);
    for (int r = 0; r < 8; r++) begin
      wr(A_IX, 8'(1 << (r % 4)));
      wr(A_DV, 8'(r));
      wr(A_IX, 8'h02);
      rd_chk(A_DV, 8'(r));
      tick_gap(n);
      chk_sig(48'({clk_div_ratio, 8'(n)}), 48'({3'(r), 8'(r + 1)}));
    end
  endtask

  task automatic t_local;
    wr(A_IX, 8'hFF);
    rd_chk(A_IX, 8'h3F);
    wr(A_LC, 8'h5C);
    chk_sig(local_values, {6{8'h5C}});
    for (int k = 0; k < 6; k++) begin
      wr(A_IX, 8'(1 << k));
      wr(A_LC, 8'(8'h10 + k));
    end
    chk_sig(local_values, 48'h151413121110);
    wr(A_IX, 8'h04);
    chk_sig(48'(chan_index), 48'h04);
    rd_chk(A_LC, 8'h12);
    wr(A_IX, 8'h3F);
    rd_chk(A_LC, 8'h10);
  endtask

  task automatic t_stream;
    logic [7:0] x;
    // two bytes step down from the duty register to the power register
    i_master.frame(1'b0, 2'h1, A_DC, 16'h0102, lsb_mode, x);
    chk_sig(48'({dcs_enable, standby}), 48'h3);
    rd_chk(A_PW, 8'h02);
    // two-byte read: the model keeps the last byte, from the power register
    i_master.frame(1'b1, 2'h1, A_DC, 16'h0000, lsb_mode, x);
    chk_byte(x, 8'h02);
    wr(A_PW, 8'h00);
  endtask

  task automatic t_lsb;
    logic [7:0] x;
    wr(A_PC, 8'h42);
    lsb_mode = 1'b1;
    chk_sig(48'(lsb_first), 48'h1);
    rd_chk(A_PC, 8'h5A);
    wr(A_DV, 8'h05);
    rd_chk(A_DV, 8'h05);
    // address steps upward in this order: power, then duty register
    i_master.frame(1'b0, 2'h1, A_PW, 16'h0200, lsb_mode, x);
    chk_sig(48'({dcs_enable, standby}), 48'h1);
    wr(A_PC, 8'h18);
    lsb_mode = 1'b0;
    chk_sig(48'(lsb_first), 48'h0);
    // one nibble alone is enough to select LSB first; writing zero to both switches back
    wr(A_PC, 8'h02);
    lsb_mode = 1'b1;
    chk_sig(48'(lsb_first), 48'h1);
    wr(A_PC, 8'h00);
    lsb_mode = 1'b0;
    chk_sig(48'(lsb_first), 48'h0);
  endtask

  task automatic t_soft;
    logic [7:0] code [2] = '{8'h20, 8'h04};
    for (int j = 0; j < 2; j++) begin
      wr(A_PW, 8'h02);
      wr(A_IX, 8'h01);
      wr(A_LC, 8'h33);
      wr(A_PC, code[j]);
      chk_sig(48'({chan_index, standby, dcs_enable, clk_div_ratio}), 48'h7E8);
      chk_sig(local_values, 48'h0);
      rd_chk(A_PC, 8'h18);
    end
  endtask

  task automatic t_override;
    int p0;
    p0 = pulses;
    wr(A_XF, 8'h01);
    chk_sig(48'(pulses - p0), 48'h1);
    wr(A_XF, 8'h00);
    chk_sig(48'(pulses - p0), 48'h1);
    rd_chk(A_XF, 8'h00);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    rst = 1'b1;
    pdwn_pin = 1'b0;
    lsb_mode = 1'b0;
    junk_r = 1'b0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_defaults;
    t_power;
    t_clock;
    t_local;
    t_stream;
    t_lsb;
    t_soft;
    t_override;
    stop_test;
  end

  // whole run needs about 25000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test;
  end
endmodule

// file: sim/asrb_spi_master.sv
// controller model driving the three-wire serial port of the bank
// assumes ref_clk from the bench; pins change only at ref_clk falls
`timescale 1ns/10ps
module asrb_spi_master (
  input wire logic ref_clk,
  input wire logic sdio_pin,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic m_out,
  output logic m_oe
);
  // half serial period; the bank needs at least four ref_clk cycles
  localparam int HALF = 5;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    m_out = 1'b0;
    m_oe = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // one frame of one or two bytes, first byte in wdata[15:8]
  task automatic frame(input logic rd, input logic [1:0] wl, input logic [12:0] addr,
                       input logic [15:0] wdata, input logic lsb, output logic [7:0] rdata);
    logic [15:0] ins;
    logic [7:0] bt;
    int n;
    int k;
    ins = {rd, wl, addr};
    n = 24 + 8 * int'(wl);
    rdata = 8'h00;
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    gap(3);
    for (int i = 0; i < n; i++) begin
      k = (i - 16) % 8;
      bt = (i < 24) ? wdata[15:8] : wdata[7:0];
      // let go of the line once a read address is out
      m_oe = !(rd && i >= 16);
      if (i < 16)
        m_out = lsb ? ins[i] : ins[15-i];
      else
        m_out = lsb ? bt[k] : bt[7-k];
      gap(HALF);
      if (rd && i >= 16)
        rdata[lsb ? k : 7 - k] = sdio_pin;
      spi_sclk = 1'b1;
      gap(HALF);
      spi_sclk = 1'b0;
    end
    gap(HALF);
    spi_cs_n = 1'b1;
    m_oe = 1'b0;
    gap(4);
  endtask
endmodule
